//--- fzdc_top.sv
// Two-zone fan duty controller with AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "fzdc_consts.svh"
module fzdc_top #(
	parameter logic [7:0]  Z1_UP_TEMP = `FZ_Z1_UP_TEMP,
	parameter logic [7:0]  Z1_DN_TEMP = `FZ_Z1_DN_TEMP,
	parameter logic [7:0]  Z2_UP_TEMP = `FZ_Z2_UP_TEMP,
	parameter logic [7:0]  Z2_DN_TEMP = `FZ_Z2_DN_TEMP,
	parameter logic [6:0]  Z1_STEP    = `FZ_STEP,
	parameter logic [6:0]  Z2_STEP    = `FZ_STEP,
	parameter logic [31:0] Z1_UP_CYC  = `FZ_Z1_UP_S * `FZ_CLK_HZ,
	parameter logic [31:0] Z1_DN_CYC  = `FZ_Z1_DN_S * `FZ_CLK_HZ,
	parameter logic [31:0] Z2_UP_CYC  = `FZ_Z2_UP_S * `FZ_CLK_HZ,
	parameter logic [31:0] Z2_DN_CYC  = `FZ_Z2_DN_S * `FZ_CLK_HZ
) (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic [7:0]  cpu_temperature_in,
	input  wire logic [7:0]  graphics_temperature_in,
	input  wire logic        graphics_temperature_valid_in,
	input  wire logic [7:0]  mainboard_temperature_in,
	input  wire logic [4:0]  fan_fail_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	output logic             irq_out,
	output logic [6:0]       zone2_fan_a_duty_out,
	output logic [6:0]       zone2_fan_b_duty_out,
	output logic [6:0]       zone1_fan_a_duty_out,
	output logic [6:0]       zone1_fan_b_duty_out,
	output logic [6:0]       zone1_fan_c_duty_out
);
	fzdc_pkg::fzdc_top_t q;
	fzdc_pkg::fzdc_top_t d;

	logic [31:0] lane;
	logic [31:0] mrg;
	logic [4:0]  clr;
	logic [4:0]  evt;
	logic [3:0]  lim;
	logic        fail_any;
	logic        force_full;

	fzdc_zone_if z1_if ();
	fzdc_zone_if z2_if ();

	// Byte enables widened to a bit mask
	function automatic logic [31:0] fzdc_lanes(input logic [3:0] strb);
		fzdc_lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	function automatic logic [31:0] fzdc_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		fzdc_merge = (old_v & ~fzdc_lanes(strb)) | (new_v & fzdc_lanes(strb));
	endfunction

	assign fail_any   = |q.pins[`FZ_PIN_FAIL];
	assign force_full = fail_any | q.fw;

	assign z1_if.temp       = q.pins[`FZ_PIN_CPU];
	assign z1_if.temp_ok    = 1'b1;
	assign z1_if.force_full = force_full;
	assign z2_if.temp       = q.pins[`FZ_PIN_GFX];
	assign z2_if.temp_ok    = q.pins[`FZ_PIN_GOK];
	assign z2_if.force_full = force_full;

	fzdc_zone #(
		.UP_TEMP (Z1_UP_TEMP),
		.DN_TEMP (Z1_DN_TEMP),
		.STEP    (Z1_STEP),
		.UP_CYC  (Z1_UP_CYC),
		.DN_CYC  (Z1_DN_CYC)
	) u_zone1 (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.zio      (z1_if.zone)
	);

	fzdc_zone #(
		.UP_TEMP (Z2_UP_TEMP),
		.DN_TEMP (Z2_DN_TEMP),
		.STEP    (Z2_STEP),
		.UP_CYC  (Z2_UP_CYC),
		.DN_CYC  (Z2_DN_CYC)
	) u_zone2 (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.zio      (z2_if.zone)
	);

	always_comb begin
		d    = q;
		lane = 32'h0;
		mrg  = 32'h0;
		clr  = 5'h0;
		evt  = 5'h0;
		lim  = 4'h0;

		// Three-stage pin synchroniser; a word is taken once stages two and three agree
		d.s1 = {fan_fail_in, mainboard_temperature_in, graphics_temperature_valid_in,
			graphics_temperature_in, cpu_temperature_in};
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3) begin
			d.pins = q.s3;
		end

		// Limit flags; graphics limits mean nothing without a valid reading
		lim[`FZ_EV_MB_NC] = q.pins[`FZ_PIN_MB] >= `FZ_MB_NC;
		lim[`FZ_EV_MB_CR] = q.pins[`FZ_PIN_MB] >= `FZ_MB_CR;
		lim[`FZ_EV_GFX_NC] = q.pins[`FZ_PIN_GOK] &&
			(q.pins[`FZ_PIN_GFX] >= `FZ_GFX_NC);
		lim[`FZ_EV_GFX_CR] = q.pins[`FZ_PIN_GOK] &&
			(q.pins[`FZ_PIN_GFX] >= `FZ_GFX_CR);
		d.lim_prev  = lim;
		d.fail_prev = fail_any;
		evt[`FZ_EV_LIM] = lim & ~q.lim_prev;
		evt[`FZ_EV_FAN] = fail_any & ~q.fail_prev;

		// Write address and data may arrive in either order
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata_in;
			d.wstrb = s_axi_wstrb_in;
		end
		if (q.bvalid && s_axi_bready_in) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = `FZ_RESP_OKAY;
			lane     = fzdc_lanes(q.wstrb);
			if (q.awaddr == `FZ_REG_CTRL) begin
				// Only bit zero is live; other written bits are dropped
				mrg  = fzdc_merge({31'h0, q.fw}, q.wdata, q.wstrb);
				d.fw = mrg[`FZ_CTRL_FW];
			end else if (q.awaddr == `FZ_REG_STATUS) begin
				clr = q.wdata[`FZ_EV_ALL] & lane[`FZ_EV_ALL];
			end else if (q.awaddr == `FZ_REG_MASK) begin
				mrg    = fzdc_merge({27'h0, q.mask}, q.wdata, q.wstrb);
				d.mask = mrg[`FZ_EV_ALL];
			end else if (q.awaddr == `FZ_REG_LIMITS || q.awaddr == `FZ_REG_DUTY ||
				q.awaddr == `FZ_REG_TEMPS || q.awaddr == `FZ_REG_FAILS) begin
				d.bresp = `FZ_RESP_OKAY;
			end else begin
				d.bresp = `FZ_RESP_SLVERR;
			end
		end

		// A new event beats a clear in the same cycle
		d.status = (q.status & ~clr) | evt;

		if (q.rvalid && s_axi_rready_in) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			d.rvalid = 1'b1;
			d.rresp  = `FZ_RESP_OKAY;
			d.rdata  = 32'h0;
			if (s_axi_araddr_in == `FZ_REG_CTRL) begin
				d.rdata[`FZ_CTRL_FW] = q.fw;
			end else if (s_axi_araddr_in == `FZ_REG_STATUS) begin
				d.rdata[`FZ_EV_ALL] = q.status;
			end else if (s_axi_araddr_in == `FZ_REG_MASK) begin
				d.rdata[`FZ_EV_ALL] = q.mask;
			end else if (s_axi_araddr_in == `FZ_REG_LIMITS) begin
				d.rdata[`FZ_EV_LIM] = lim;
			end else if (s_axi_araddr_in == `FZ_REG_DUTY) begin
				d.rdata[`FZ_RD_Z1] = z1_if.duty;
				d.rdata[`FZ_RD_Z2] = z2_if.duty;
			end else if (s_axi_araddr_in == `FZ_REG_TEMPS) begin
				d.rdata[`FZ_RD_TCPU] = q.pins[`FZ_PIN_CPU];
				d.rdata[`FZ_RD_TGFX] = q.pins[`FZ_PIN_GFX];
				d.rdata[`FZ_RD_TMB]  = q.pins[`FZ_PIN_MB];
				d.rdata[`FZ_RD_TGOK] = q.pins[`FZ_PIN_GOK];
			end else if (s_axi_araddr_in == `FZ_REG_FAILS) begin
				d.rdata[`FZ_RD_FAIL]  = q.pins[`FZ_PIN_FAIL];
				d.rdata[`FZ_RD_FORCE] = force_full;
			end else begin
				d.rresp = `FZ_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// One write and one read at a time keeps the slave free of queues
	assign s_axi_awready_out = !q.aw_got && !q.bvalid;
	assign s_axi_wready_out  = !q.w_got && !q.bvalid;
	assign s_axi_bvalid_out  = q.bvalid;
	assign s_axi_bresp_out   = q.bresp;
	assign s_axi_arready_out = !q.rvalid;
	assign s_axi_rvalid_out  = q.rvalid;
	assign s_axi_rdata_out   = q.rdata;
	assign s_axi_rresp_out   = q.rresp;

	assign irq_out = |(q.status & q.mask);

	assign zone1_fan_a_duty_out = z1_if.duty;
	assign zone1_fan_b_duty_out = z1_if.duty;
	assign zone1_fan_c_duty_out = z1_if.duty;
	assign zone2_fan_a_duty_out = z2_if.duty;
	assign zone2_fan_b_duty_out = z2_if.duty;
endmodule

//--- fzdc_consts.svh
// Constants of the fan zone duty controller
`ifndef FZDC_CONSTS_SVH
`define FZDC_CONSTS_SVH

`define FZ_CLK_HZ      32'h02faf080
`define FZ_DUTY_IDLE   7'h05
`define FZ_DUTY_FULL   7'h64
`define FZ_STEP        7'h03
`define FZ_Z1_UP_TEMP  8'h50
`define FZ_Z1_DN_TEMP  8'h4b
`define FZ_Z2_UP_TEMP  8'h56
`define FZ_Z2_DN_TEMP  8'h4c
`define FZ_Z1_UP_S     32'h1
`define FZ_Z1_DN_S     32'h3
`define FZ_Z2_UP_S     32'h2
`define FZ_Z2_DN_S     32'h1
`define FZ_MB_NC       8'h36
`define FZ_MB_CR       8'h37
`define FZ_GFX_NC      8'h5c
`define FZ_GFX_CR      8'h5d

`define FZ_REG_CTRL    8'h00
`define FZ_REG_STATUS  8'h04
`define FZ_REG_MASK    8'h08
`define FZ_REG_LIMITS  8'h0c
`define FZ_REG_DUTY    8'h10
`define FZ_REG_TEMPS   8'h14
`define FZ_REG_FAILS   8'h18

`define FZ_CTRL_FW     0
`define FZ_EV_ALL      4:0
`define FZ_EV_LIM      3:0
`define FZ_EV_MB_NC    0
`define FZ_EV_MB_CR    1
`define FZ_EV_GFX_NC   2
`define FZ_EV_GFX_CR   3
`define FZ_EV_FAN      4

`define FZ_PIN_W       30
`define FZ_PIN_CPU     7:0
`define FZ_PIN_GFX     15:8
`define FZ_PIN_GOK     16
`define FZ_PIN_MB      24:17
`define FZ_PIN_FAIL    29:25

`define FZ_RD_Z1       6:0
`define FZ_RD_Z2       14:8
`define FZ_RD_TCPU     7:0
`define FZ_RD_TGFX     15:8
`define FZ_RD_TMB      23:16
`define FZ_RD_TGOK     24
`define FZ_RD_FAIL     4:0
`define FZ_RD_FORCE    8

`define FZ_RESP_OKAY   2'h0
`define FZ_RESP_SLVERR 2'h2

`endif

//--- fzdc_pkg.sv
// Types of the fan zone duty controller
`include "fzdc_consts.svh"
package fzdc_pkg;
	typedef enum logic [1:0] {
		FZDC_HOLD = 2'h0,
		FZDC_UP   = 2'h1,
		FZDC_DOWN = 2'h2
	} fzdc_ramp_t;

	typedef struct packed {
		fzdc_ramp_t mode;
		logic [31:0] cnt;
		logic [6:0]  duty;
	} fzdc_zone_t;

	typedef struct packed {
		logic [`FZ_PIN_W-1:0] s1;
		logic [`FZ_PIN_W-1:0] s2;
		logic [`FZ_PIN_W-1:0] s3;
		logic [`FZ_PIN_W-1:0] pins;
		logic                 fw;
		logic [4:0]           status;
		logic [4:0]           mask;
		logic [3:0]           lim_prev;
		logic                 fail_prev;
		logic                 aw_got;
		logic [7:0]           awaddr;
		logic                 w_got;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
	} fzdc_top_t;
endpackage

//--- fzdc_zone_if.sv
// Link between the controller core and one zone ramp engine
`timescale 1ns/10ps
interface fzdc_zone_if;
	logic [7:0] temp;
	logic       temp_ok;
	logic       force_full;
	logic [6:0] duty;
	modport zone (input temp, input temp_ok, input force_full, output duty);
	modport ctrl (output temp, output temp_ok, output force_full, input duty);
endinterface

//--- fzdc_zone.sv
// Ramp engine of one cooling zone
`timescale 1ns/10ps
`include "fzdc_consts.svh"
module fzdc_zone #(
	parameter logic [7:0]  UP_TEMP = `FZ_Z1_UP_TEMP,
	parameter logic [7:0]  DN_TEMP = `FZ_Z1_DN_TEMP,
	parameter logic [6:0]  STEP    = `FZ_STEP,
	parameter logic [31:0] UP_CYC  = `FZ_Z1_UP_S * `FZ_CLK_HZ,
	parameter logic [31:0] DN_CYC  = `FZ_Z1_DN_S * `FZ_CLK_HZ
) (
	input  wire logic  clk_in,
	input  wire logic  reset_in,
	fzdc_zone_if.zone  zio
);
	fzdc_pkg::fzdc_zone_t q;
	fzdc_pkg::fzdc_zone_t d;

	always_comb begin
		d = q;
		if (zio.force_full) begin
			d.duty = `FZ_DUTY_FULL;
			d.mode = fzdc_pkg::FZDC_HOLD;
			d.cnt  = 32'h0;
		end else if (!zio.temp_ok) begin
			// No reading, no ramp; the duty stays where it is
			d.mode = fzdc_pkg::FZDC_HOLD;
			d.cnt  = 32'h0;
		end else if (zio.temp >= UP_TEMP) begin
			if (q.mode != fzdc_pkg::FZDC_UP) begin
				d.mode = fzdc_pkg::FZDC_UP;
				d.cnt  = 32'h0;
			end else if (q.cnt == UP_CYC - 32'h1) begin
				d.cnt = 32'h0;
				// Saturate at full duty
				if (q.duty > `FZ_DUTY_FULL - STEP) begin
					d.duty = `FZ_DUTY_FULL;
				end else begin
					d.duty = q.duty + STEP;
				end
			end else begin
				d.cnt = q.cnt + 32'h1;
			end
		end else if (zio.temp < DN_TEMP) begin
			if (q.mode != fzdc_pkg::FZDC_DOWN) begin
				d.mode = fzdc_pkg::FZDC_DOWN;
				d.cnt  = 32'h0;
			end else if (q.cnt == DN_CYC - 32'h1) begin
				d.cnt = 32'h0;
				// Never below idle
				if (q.duty < `FZ_DUTY_IDLE + STEP) begin
					d.duty = `FZ_DUTY_IDLE;
				end else begin
					d.duty = q.duty - STEP;
				end
			end else begin
				d.cnt = q.cnt + 32'h1;
			end
		end else begin
			// Dead band restarts the interval, so a brief dip never steps early
			d.mode = fzdc_pkg::FZDC_HOLD;
			d.cnt  = 32'h0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			q <= '{mode: fzdc_pkg::FZDC_HOLD, cnt: 32'h0, duty: `FZ_DUTY_IDLE};
		end else begin
			q <= d;
		end
	end

	assign zio.duty = q.duty;
endmodule

//--- fzdc_properties.sv
// Port assertions of the fan zone controller
`timescale 1ns/10ps
module fzdc_props #(
	parameter logic [31:0] Z1_UP_CYC = 32'h8,
	parameter logic [31:0] Z1_DN_CYC = 32'hc,
	parameter logic [31:0] Z2_UP_CYC = 32'ha,
	parameter logic [31:0] Z2_DN_CYC = 32'h6
) (
	input wire logic       clk_in,
	input wire logic       reset_in,
	input wire logic       graphics_temperature_valid_in,
	input wire logic [4:0] fan_fail_in,
	input wire logic       irq_out,
	input wire logic [6:0] zone2_fan_a_duty_out,
	input wire logic [6:0] zone2_fan_b_duty_out,
	input wire logic [6:0] zone1_fan_a_duty_out,
	input wire logic [6:0] zone1_fan_b_duty_out,
	input wire logic [6:0] zone1_fan_c_duty_out
);
	wire logic [6:0] z1 = zone1_fan_a_duty_out;
	wire logic [6:0] z2 = zone2_fan_a_duty_out;
	logic [6:0]      p1_q, p2_q;
	logic [31:0]     g1_q, g2_q;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (reset_in);
	// Edges since the last duty change, to bound the step interval
	always_ff @(posedge clk_in) begin
		p1_q <= z1;
		p2_q <= z2;
		g1_q <= (reset_in || z1 != p1_q) ? 32'h1 : g1_q + 32'h1;
		g2_q <= (reset_in || z2 != p2_q) ? 32'h1 : g2_q + 32'h1;
	end
	// Sync latency is four edges plus one for the zone
	sequence fail_held;
		(fan_fail_in != 5'h00)[*7];
	endsequence
	sequence gfx_gone;
		(!graphics_temperature_valid_in && fan_fail_in == 5'h00)[*7];
	endsequence
	zone1_match_a: assert property (z1 == zone1_fan_b_duty_out && z1 == zone1_fan_c_duty_out)
		else $error("zone one fans differ");
	zone2_match_a: assert property (z2 == zone2_fan_b_duty_out)
		else $error("zone two fans differ");
	reset_idle_a: assert property (disable iff (1'b0)
		reset_in |=> z1 == 7'h05 && z2 == 7'h05 && !irq_out) else $error("reset not idle");
	duty_range_a: assert property (z1 >= 7'h05 && z1 <= 7'h64 && z2 >= 7'h05 && z2 <= 7'h64)
		else $error("duty out of range");
	fail_full_a: assert property (fail_held |-> z1 == 7'h64 && z2 == 7'h64)
		else $error("fan failure not full duty");
	zone1_step_a: assert property ($changed(z1) && z1 != 7'h64 |->
		z1 == $past(z1) + 7'h03 || z1 == $past(z1) - 7'h03 || z1 == 7'h05)
		else $error("zone one step size wrong");
	zone1_gap_a: assert property ($changed(z1) && z1 != 7'h64 |->
		g1_q >= (z1 > $past(z1) ? Z1_UP_CYC : Z1_DN_CYC)) else $error("zone one step too soon");
	zone2_gap_a: assert property ($changed(z2) && z2 != 7'h64 |->
		g2_q >= (z2 > $past(z2) ? Z2_UP_CYC : Z2_DN_CYC)) else $error("zone two step too soon");
	gfx_hold_a: assert property (gfx_gone |-> $stable(z2) || z2 == 7'h64)
		else $error("zone two ramped without reading");
endmodule

bind fzdc_top fzdc_props #(.Z1_UP_CYC(Z1_UP_CYC), .Z1_DN_CYC(Z1_DN_CYC),
	.Z2_UP_CYC(Z2_UP_CYC), .Z2_DN_CYC(Z2_DN_CYC)) i_fzdc_props (.clk_in(clk_in),
	.reset_in(reset_in), .graphics_temperature_valid_in(graphics_temperature_valid_in),
	.fan_fail_in(fan_fail_in), .irq_out(irq_out),
	.zone2_fan_a_duty_out(zone2_fan_a_duty_out), .zone2_fan_b_duty_out(zone2_fan_b_duty_out),
	.zone1_fan_a_duty_out(zone1_fan_a_duty_out), .zone1_fan_b_duty_out(zone1_fan_b_duty_out),
	.zone1_fan_c_duty_out(zone1_fan_c_duty_out));

//--- fzdc_sens.sv
// Behavioural temperature sensors and fan-failure sources
`timescale 1ns/10ps
module fzdc_sens (
	input wire logic       clk_in,
	input wire logic [7:0] cpu_set_in,
	input wire logic [7:0] gfx_set_in,
	input wire logic       gok_set_in,
	input wire logic [7:0] mb_set_in,
	input wire logic [4:0] fail_set_in,
	output logic [7:0]     cpu_out = 8'h00,
	output logic [7:0]     gfx_out = 8'h00,
	output logic           gok_out = 1'b0,
	output logic [7:0]     mb_out = 8'h00,
	output logic [4:0]     fail_out = 5'h00
);
	logic [7:0] gfx_keep_q = 8'h00;
	always @(posedge clk_in) begin
		cpu_out <= cpu_set_in;
		mb_out <= mb_set_in;
		fail_out <= fail_set_in;
		gok_out <= gok_set_in;
		if (gok_set_in)
			gfx_keep_q <= gfx_set_in;
		// A dropped reading shows a hot-looking inverse, not a stale value
		gfx_out <= gok_set_in ? gfx_set_in : ~gfx_keep_q;
	end
endmodule

//--- tb.sv
// Self-checking bench of the fan zone controller
`timescale 1ns/10ps
`include "fzdc_consts.svh"
module tb;
	// Short intervals keep the run brief
	localparam int U1 = 8;
	localparam int D1 = 12;
	localparam int U2 = 10;
	localparam int D2 = 6;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [7:0]  cpu_s = 8'h3c, gfx_s = 8'h3c, mb_s = 8'h1e, awaddr = 8'h00, araddr = 8'h00;
	logic        gok_s = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [4:0]  fail_s = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [7:0]  cpu, gfx, mb;
	logic [4:0]  fail;
	logic        gok, awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [6:0]  z1a, z1b, z1c, z2a, z2b;
	int          err_total = 0;
	int          checks = 0;
	int          cyc = 0;

	always #10 clk_in = ~clk_in;

	fzdc_sens i_fzdc_sens (.clk_in(clk_in), .cpu_set_in(cpu_s), .gfx_set_in(gfx_s),
		.gok_set_in(gok_s), .mb_set_in(mb_s), .fail_set_in(fail_s), .cpu_out(cpu),
		.gfx_out(gfx), .gok_out(gok), .mb_out(mb), .fail_out(fail));
	fzdc_top #(.Z1_UP_CYC(U1), .Z1_DN_CYC(D1), .Z2_UP_CYC(U2), .Z2_DN_CYC(D2)) i_fzdc_top (
		.clk_in(clk_in), .reset_in(reset_in), .cpu_temperature_in(cpu),
		.graphics_temperature_in(gfx), .graphics_temperature_valid_in(gok),
		.mainboard_temperature_in(mb), .fan_fail_in(fail), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .irq_out(irq), .zone2_fan_a_duty_out(z2a),
		.zone2_fan_b_duty_out(z2b), .zone1_fan_a_duty_out(z1a),
		.zone1_fan_b_duty_out(z1b), .zone1_fan_c_duty_out(z1c));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Each bus task ends one edge after release so the next never re-drives in that step
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while ((awvalid || wvalid) && n < 50);
		while (bvalid !== 1'b1 && n < 50) begin
			@(posedge clk_in);
			n++;
		end
		rs = bresp;
		bready <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (arvalid && n < 50);
		while (rvalid !== 1'b1 && n < 50) begin
			@(posedge clk_in);
			n++;
		end
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge clk_in);
	endtask

	function automatic logic [6:0] dz(input int z);
		return (z == 1) ? z1a : z2a;
	endfunction

	// Skips the first step, whose start lags the threshold crossing, then times the next
	task automatic meas(input int z, input logic [6:0] dl, input int gap);
		logic [6:0] v;
		int n;
		repeat (2) begin
			v = dz(z);
			n = 0;
			while (dz(z) === v && n < 400) begin
				@(posedge clk_in);
				n++;
			end
		end
		v = v + dl;
		chk("duty step", v, dz(z));
		chk("step interval", gap, n);
	endtask

	task automatic hold(input int z, input logic [6:0] e);
		repeat (8) @(posedge clk_in);
		repeat (40) begin
			@(posedge clk_in);
			chk("held duty", e, dz(z));
		end
	endtask

	task automatic t_reset;
		chk("zone1 idle", 7'h05, z1a);
		chk("zone2 idle", 7'h05, z2b);
		chk("zone1 fan c", 7'h05, z1c);
		chk("irq idle", 1'b0, irq);
		rd(`FZ_REG_DUTY, d, r);
		chk("duty reg", 32'h505, d);
		rd(`FZ_REG_MASK, d, r);
		chk("mask reset", 32'h0, d);
		wr(`FZ_REG_MASK, 32'h1f, r);
		chk("write resp", `FZ_RESP_OKAY, r);
		rd(`FZ_REG_MASK, d, r);
		chk("mask rw", 32'h1f, d);
		chk("read resp", `FZ_RESP_OKAY, r);
		rd(8'h1c, d, r);
		chk("unmapped resp", `FZ_RESP_SLVERR, r);
		chk("unmapped data", 32'h0, d);
		wr(8'h02, 32'h1, r);
		chk("misaligned resp", `FZ_RESP_SLVERR, r);
		wr(`FZ_REG_MASK, 32'h0, r);
		$display("test reset done");
	endtask

	task automatic t_zones;
		cpu_s <= 8'h50;
		meas(1, 7'h03, U1);
		cpu_s <= 8'h4b;
		hold(1, 7'h0b);
		cpu_s <= 8'h4a;
		meas(1, 7'h7d, D1);
		hold(1, 7'h05);
		gfx_s <= 8'h56;
		meas(2, 7'h03, U2);
		gok_s <= 1'b0;
		hold(2, 7'h0b);
		gok_s <= 1'b1;
		gfx_s <= 8'h4b;
		meas(2, 7'h7d, D2);
		$display("test zones done");
	endtask

	task automatic t_force;
		fail_s <= 5'h04;
		repeat (10) @(posedge clk_in);
		chk("fail zone1", 7'h64, z1b);
		chk("fail zone2", 7'h64, z2a);
		rd(`FZ_REG_STATUS, d, r);
		chk("fan event", 32'h10, d);
		chk("irq masked", 1'b0, irq);
		wr(`FZ_REG_MASK, 32'h10, r);
		chk("irq raised", 1'b1, irq);
		fail_s <= 5'h00;
		wr(`FZ_REG_STATUS, 32'h0, r);
		chk("irq kept", 1'b1, irq);
		wr(`FZ_REG_STATUS, 32'h10, r);
		chk("irq cleared", 1'b0, irq);
		meas(1, 7'h7d, D1);
		wr(`FZ_REG_CTRL, 32'h1, r);
		repeat (2) @(posedge clk_in);
		chk("update force", 7'h64, z1c);
		rd(`FZ_REG_FAILS, d, r);
		chk("force flag", 32'h100, d);
		cpu_s <= 8'h50;
		wr(`FZ_REG_CTRL, 32'h0, r);
		hold(1, 7'h64);
		cpu_s <= 8'h3c;
		wr(`FZ_REG_MASK, 32'h0, r);
		$display("test force done");
	endtask

	task automatic t_limits;
		mb_s <= 8'h36;
		repeat (8) @(posedge clk_in);
		rd(`FZ_REG_LIMITS, d, r);
		chk("limit 54", 32'h1, d);
		mb_s <= 8'h37;
		gfx_s <= 8'h5d;
		repeat (8) @(posedge clk_in);
		rd(`FZ_REG_LIMITS, d, r);
		chk("limit 55 93", 32'hf, d);
		rd(`FZ_REG_STATUS, d, r);
		chk("limit events", 32'hf, d);
		rd(`FZ_REG_TEMPS, d, r);
		chk("temps reg", 32'h01375d3c, d);
		$display("test limits done");
	endtask

	initial begin
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		t_reset;
		t_zones;
		t_force;
		t_limits;
		test_done;
	end

	// Ceiling well above the few hundred edges the tests need
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			test_done;
		end
	end
endmodule
